// ==== logic/ebr_pkg.sv ====
// Purpose: shared constants for the external bus ready/wait-state controller
// Assumes: one system clock, cycle phases counted in clock periods
// Notes: phase ranges follow the programmable bus cycle phase table
package ebr_pkg;
  // ****************************************
  // phase ranges and widths
  // ****************************************
  localparam int unsigned ACC_MAX = 32;
  localparam int unsigned ACC_W = 6;
  localparam int unsigned AB_W = 3;
  localparam int unsigned C_W = 2;
  localparam int unsigned F_W = 2;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 24;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SYNC_STAGES = 2;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic RST_STROBE_N = 1'h1;
  localparam logic RST_BUSY = 1'h0;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_CMD = 6'h04,
    ST_ACC = 6'h08,
    ST_WAIT = 6'h10,
    ST_HOLD = 6'h20
  } ebr_state_t;
endpackage

// ==== logic/ebr_sync.sv ====
// Purpose: two-flop synchroniser for the handshake input
// Assumes: single clock domain
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module ebr_sync
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // data
  input wire logic din,
  output logic dout
);
  logic meta;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= 1'h0;
      dout <= 1'h0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ==== logic/ebr_ctrl.sv ====
// Purpose: bus cycle sequencer with handshake-controlled wait states
// Assumes: handshake input sampled on rising clk; config stable per cycle
// Notes: reference clock output is a registered toggle of clk, running at half the clk rate
// Function
// - selectable active level for handshake input
// - synchronous mode samples input directly
// - asynchronous mode adds synchroniser stage
// - sample point follows programmed phase lengths
// - inactive sample inserts one more wait state
// - active sample ends cycle, deasserts strobe
// - async sample point later by synchroniser delay
// - ignore handshake until access phase elapses
// - handshake may extend access phase length
// - read data captured at strobe rising edge
`timescale 1ns/10ps
module ebr_ctrl
#(
  parameter int unsigned DW = ebr_pkg::DATA_W,
  parameter int unsigned AW = ebr_pkg::ADDR_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // request side
  input wire logic req,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  // cycle configuration
  input wire logic [ebr_pkg::AB_W-1:0] addr_phase_length,
  input wire logic [ebr_pkg::C_W-1:0] cmd_phase_length,
  input wire logic [ebr_pkg::ACC_W-1:0] access_phase_length,
  input wire logic [ebr_pkg::F_W-1:0] hold_phase_length,
  input wire logic hs_enable,
  input wire logic hs_active_high,
  input wire logic hs_async,
  // external bus
  input wire logic handshake_in,
  input wire logic [DW-1:0] bus_rdata,
  output logic [AW-1:0] bus_addr,
  output logic [DW-1:0] bus_wdata,
  output logic rd_n,
  output logic wr_n,
  output logic reference_clock_output,
  // status
  output logic busy,
  output logic done,
  output logic [DW-1:0] rdata,
  output logic handshake_wait_state
);
  ebr_pkg::ebr_state_t state;
  logic [ebr_pkg::ACC_W-1:0] cnt;
  logic is_write;
  logic hs_sync;
  logic hs_raw_act;
  logic hs_sync_act;
  logic hs_seen;
  logic sample_now;
  logic [ebr_pkg::ACC_W-1:0] acc_len;

  function automatic logic [ebr_pkg::ACC_W-1:0] at_least_one(input logic [ebr_pkg::ACC_W-1:0] v);
    at_least_one = (v == 6'h00) ? 6'h01 : v;
  endfunction

  // ****************************************
  // handshake qualification
  // ****************************************
  ebr_sync u_sync
  (
    .clk(clk),
    .arst_n(arst_n),
    .din(handshake_in),
    .dout(hs_sync)
  );

  assign hs_raw_act = handshake_in ~^ hs_active_high;
  assign hs_sync_act = hs_sync ~^ hs_active_high;
  // async path sees a later copy, so its sample point lags by the sync delay
  assign hs_seen = hs_async ? hs_sync_act : hs_raw_act;
  assign acc_len = at_least_one(access_phase_length);
  // handshake only looked at once the programmed access wait states ran out
  assign sample_now = (state == ebr_pkg::ST_ACC && cnt == 6'h01) || state == ebr_pkg::ST_WAIT;

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ebr_pkg::ST_IDLE;
      cnt <= 6'h00;
      is_write <= 1'h0;
    end
    else
    begin
      unique case (state)
        ebr_pkg::ST_IDLE:
        begin
          if (req)
          begin
            state <= ebr_pkg::ST_ADDR;
            is_write <= req_write;
            cnt <= {3'h0, (addr_phase_length == 3'h0) ? 3'h1 : addr_phase_length};
          end
        end
        ebr_pkg::ST_ADDR:
        begin
          if (cnt == 6'h01)
          begin
            state <= (cmd_phase_length == 2'h0) ? ebr_pkg::ST_ACC : ebr_pkg::ST_CMD;
            cnt <= (cmd_phase_length == 2'h0) ? acc_len : {4'h0, cmd_phase_length};
          end
          else
            cnt <= cnt - 6'h01;
        end
        ebr_pkg::ST_CMD:
        begin
          if (cnt == 6'h01)
          begin
            state <= ebr_pkg::ST_ACC;
            cnt <= acc_len;
          end
          else
            cnt <= cnt - 6'h01;
        end
        ebr_pkg::ST_ACC, ebr_pkg::ST_WAIT:
        begin
          if (sample_now)
          begin
            if (!hs_enable || hs_seen)
            begin
              state <= (hold_phase_length == 2'h0) ? ebr_pkg::ST_IDLE : ebr_pkg::ST_HOLD;
              cnt <= {4'h0, hold_phase_length};
            end
            else
              state <= ebr_pkg::ST_WAIT;
          end
          else
            cnt <= cnt - 6'h01;
        end
        ebr_pkg::ST_HOLD:
        begin
          if (cnt == 6'h01)
            state <= ebr_pkg::ST_IDLE;
          else
            cnt <= cnt - 6'h01;
        end
        default:
          state <= ebr_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // bus outputs
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_addr <= '0;
      bus_wdata <= '0;
      rd_n <= ebr_pkg::RST_STROBE_N;
      wr_n <= ebr_pkg::RST_STROBE_N;
    end
    else
    begin
      if (state == ebr_pkg::ST_IDLE && req)
      begin
        bus_addr <= req_addr;
        bus_wdata <= req_wdata;
      end
      if ((state == ebr_pkg::ST_ADDR && cnt == 6'h01) || state == ebr_pkg::ST_CMD && cnt == 6'h01)
      begin
        if (state == ebr_pkg::ST_CMD || cmd_phase_length == 2'h0)
        begin
          rd_n <= is_write;
          wr_n <= !is_write;
        end
      end
      else if (sample_now && (!hs_enable || hs_seen))
      begin
        rd_n <= 1'h1;
        wr_n <= 1'h1;
      end
    end
  end

  // ****************************************
  // status and read data
  // ****************************************
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy <= ebr_pkg::RST_BUSY;
      done <= 1'h0;
      rdata <= '0;
      handshake_wait_state <= 1'h0;
      reference_clock_output <= 1'h0;
    end
    else
    begin
      reference_clock_output <= !reference_clock_output;
      busy <= (state != ebr_pkg::ST_IDLE) || req;
      done <= sample_now && (!hs_enable || hs_seen);
      // same edge that raises the read strobe latches the data
      if (sample_now && (!hs_enable || hs_seen) && !is_write)
        rdata <= bus_rdata;
      handshake_wait_state <= sample_now && hs_enable && !hs_seen;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_end_strobe;
    @(posedge clk) disable iff (!arst_n)
      (sample_now && (!hs_enable || hs_seen)) |=> (rd_n && wr_n && done);
  endproperty
  a_end_strobe: assert property (p_end_strobe) else $error("strobe not released at end");

  property p_wait_insert;
    @(posedge clk) disable iff (!arst_n)
      (sample_now && hs_enable && !hs_seen) |=> (state == ebr_pkg::ST_WAIT && handshake_wait_state);
  endproperty
  a_wait_insert: assert property (p_wait_insert) else $error("wait state missing");

  property p_no_hs_length;
    @(posedge clk) disable iff (!arst_n)
      (state == ebr_pkg::ST_ACC && !hs_enable && cnt == 6'h01) |=> (state != ebr_pkg::ST_ACC && state != ebr_pkg::ST_WAIT);
  endproperty
  a_no_hs_length: assert property (p_no_hs_length) else $error("disabled handshake did not end");

  property p_ignore_early;
    @(posedge clk) disable iff (!arst_n)
      (state == ebr_pkg::ST_ACC && cnt > 6'h01) |=> (state == ebr_pkg::ST_ACC && !done);
  endproperty
  a_ignore_early: assert property (p_ignore_early) else $error("handshake used too early");

  // checks the real two-edge lag of the pin, not the select expression
  property p_async_lag;
    @(posedge clk) disable iff (!arst_n)
      (hs_async && sample_now) |-> (hs_seen == ($past(handshake_in, 2) ~^ hs_active_high));
  endproperty
  a_async_lag: assert property (p_async_lag) else $error("async path not synchronised");

  property p_sync_direct;
    @(posedge clk) disable iff (!arst_n)
      (!hs_async && hs_enable && sample_now && (handshake_in ~^ hs_active_high)) |=> done;
  endproperty
  a_sync_direct: assert property (p_sync_direct) else $error("sync path not direct");

  property p_read_capture;
    @(posedge clk) disable iff (!arst_n)
      (sample_now && (!hs_enable || hs_seen) && !is_write) |=> (rdata == $past(bus_rdata));
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("read data not captured");

  property p_acc_entry;
    @(posedge clk) disable iff (!arst_n)
      (state != ebr_pkg::ST_ACC ##1 state == ebr_pkg::ST_ACC) |-> (cnt == acc_len);
  endproperty
  a_acc_entry: assert property (p_acc_entry) else $error("access length wrong");

  c_wait: cover property (@(posedge clk) disable iff (!arst_n) handshake_wait_state ##1 done);
  c_async: cover property (@(posedge clk) disable iff (!arst_n) hs_async && done);
  c_write: cover property (@(posedge clk) disable iff (!arst_n) !wr_n ##[1:40] done);
endmodule

// ==== test/ebr_partner.sv ====
// Purpose: external module answering bus cycles with the ready handshake
// Assumes: driven from the rising clk edge, like the reference clock
// Notes: ready held until strobe rises, then released
`timescale 1ns/10ps
module ebr_partner
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // behaviour
  input wire logic [5:0] delay,
  input wire logic active_high,
  input wire logic [ebr_pkg::DATA_W-1:0] data,
  // bus
  input wire logic rd_n,
  input wire logic wr_n,
  output logic handshake_in,
  output logic [ebr_pkg::DATA_W-1:0] bus_rdata
);
  logic [5:0] cnt;
  logic strobe;
  logic ready;
  assign strobe = ~(rd_n & wr_n);
  // count clocks of strobe low, clocked so ready is synchronous
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt <= 6'h00;
    else if (strobe)
      cnt <= cnt + 6'h01;
    else
      cnt <= 6'h00;
  end
  // held until the strobe trailing edge, so the synchroniser always sees it
  assign ready = strobe && (cnt >= delay);
  assign handshake_in = ready ? active_high : ~active_high;
  // released data bus shows the inverse, never a stale copy
  assign bus_rdata = rd_n ? ~data : data;
endmodule

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for the ready/wait-state controller
// Assumes: latency counted in edges from the taking edge to done
// Notes: address and hold phases one clock each
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic req = 1'h0;
  logic req_write = 1'h0;
  logic [23:0] req_addr = 24'h00A5C3;
  logic [15:0] req_wdata = 16'h3C5A;
  logic [2:0] ab_len = 3'h1;
  logic [1:0] c_len = 2'h1;
  logic [5:0] e_len = 6'h02;
  logic [1:0] f_len = 2'h1;
  logic hs_en = 1'h1;
  logic pol = 1'h1;
  logic as = 1'h0;
  logic [5:0] dly = 6'h00;
  logic [15:0] pdata = 16'hB7E1;
  logic hs_in, rd_n, wr_n, busy, done, hws;
  logic [23:0] baddr;
  logic [15:0] bwdata;
  logic rco, rco_prev;
  logic [15:0] bus_rdata, rdata;
  int fails = 0;
  int n_tests = 0;
  int lat, waits, l1;
  logic [1:0] sd;
  initial forever #50 clk = ~clk;
  ebr_ctrl ebr_ctrl_inst (.clk(clk), .arst_n(arst_n), .req(req), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .addr_phase_length(ab_len),
    .cmd_phase_length(c_len), .access_phase_length(e_len), .hold_phase_length(f_len),
    .hs_enable(hs_en), .hs_active_high(pol), .hs_async(as), .handshake_in(hs_in),
    .bus_rdata(bus_rdata), .bus_addr(baddr), .bus_wdata(bwdata), .rd_n(rd_n), .wr_n(wr_n),
    .reference_clock_output(rco), .busy(busy), .done(done), .rdata(rdata), .handshake_wait_state(hws));
  ebr_partner ebr_partner_inst (.clk(clk), .arst_n(arst_n), .delay(dly), .active_high(pol),
    .data(pdata), .rd_n(rd_n), .wr_n(wr_n), .handshake_in(hs_in), .bus_rdata(bus_rdata));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one whole bus cycle; entered and left on a rising edge
  task automatic run(input logic w, input logic [1:0] c, input logic [5:0] e, input logic a,
    input logic en, input logic p, input logic [5:0] d);
    int k;
    req_write <= w;
    c_len <= c;
    e_len <= e;
    as <= a;
    hs_en <= en;
    pol <= p;
    dly <= d;
    req <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
    lat = 0;
    waits = 0;
    k = 0;
    while (k < 200)
    begin
      @(posedge clk);
      #1;
      lat++;
      k++;
      if (hws === 1'h1)
        waits++;
      if (done === 1'h1)
      begin
        sd = {rd_n, wr_n};
        k = 200;
      end
    end
    k = 0;
    while (busy !== 1'h0 && k < 50)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    @(posedge clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_plain();
    run(1'h0, 2'h1, 6'h02, 1'h0, 1'h1, 1'h1, 6'h00);
    check(lat, 4);
    check(waits, 0);
    check(sd, 2'h3);
    check(rdata, pdata);
    check(baddr, req_addr);
    #1;
    rco_prev = rco;
    @(posedge clk);
    #1;
    check(rco, !rco_prev);
  endtask
  task automatic t_disabled();
    run(1'h0, 2'h1, 6'h02, 1'h0, 1'h0, 1'h1, 6'h28);
    check(lat, 4);
    check(waits, 0);
  endtask
  task automatic t_waits();
    run(1'h0, 2'h1, 6'h02, 1'h0, 1'h1, 1'h1, 6'h03);
    l1 = lat;
    check(lat, 4 + waits);
    check(waits, 2);
    check(waits != 0, 1'h1);
    run(1'h0, 2'h1, 6'h02, 1'h0, 1'h1, 1'h1, 6'h04);
    check(lat, l1 + 1);
  endtask
  task automatic t_async();
    run(1'h0, 2'h1, 6'h02, 1'h1, 1'h1, 1'h1, 6'h00);
    check(waits != 0, 1'h1);
    check(lat, 4 + waits);
    check(rdata, pdata);
  endtask
  task automatic t_polarity();
    for (int p = 0; p < 2; p++)
    begin
      run(1'h1, 2'h1, 6'h02, 1'h0, 1'h1, p[0], 6'h02);
      check(lat, 5);
      check(waits, 1);
      check(sd, 2'h3);
      check(bwdata, req_wdata);
    end
  endtask
  task automatic t_phases();
    run(1'h0, 2'h1, 6'h06, 1'h0, 1'h1, 1'h1, 6'h00);
    check(lat, 8);
    run(1'h0, 2'h2, 6'h03, 1'h0, 1'h1, 1'h1, 6'h00);
    check(lat, 6);
    run(1'h0, 2'h0, 6'h02, 1'h0, 1'h1, 1'h1, 6'h00);
    check(lat, 3);
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    t_plain();
    t_disabled();
    t_waits();
    t_async();
    t_polarity();
    t_phases();
    test_done();
  end
  // whole run is about a hundred clocks; this is fifty times that
  initial
  begin
    #(5000 * 100);
    fails++;
    test_done();
  end
endmodule
